//--- rtl/tscu_pkg.sv
/*
 * tscu_pkg: constants and carrier types for the task switch check unit.
 * assumes: included before the unit; nothing imported, every use is scoped.
 */
`default_nettype none

package tscu_pkg;

	// long-mode task state segment layout (byte offsets)
	localparam logic [7:0] TSS64_PSP_LO   = 8'h04;
	localparam logic [7:0] TSS64_PSP_HI   = 8'h1B;
	localparam logic [7:0] TSS64_ISP_LO   = 8'h24;
	localparam logic [7:0] TSS64_ISP_HI   = 8'h5B;
	localparam logic [7:0] TSS64_IOMAP_LO = 8'h66;
	localparam logic [7:0] TSS64_IOMAP_HI = 8'h67;
	localparam int         PTR_BYTES      = 8;

	// legacy task state segment save areas used by a switch
	localparam logic [7:0] TSS32_XLATE    = 8'h1C;
	localparam logic [7:0] TSS32_LDTSEL   = 8'h60;

	// task gate descriptor, upper word (byte +4) field positions
	localparam int         GATE_TYPE_LSB  = 8;
	localparam int         GATE_S_BIT     = 12;
	localparam int         GATE_DPL_LSB   = 13;
	localparam int         GATE_P_BIT     = 15;
	localparam logic [4:0] GATE_TASK_CODE = 5'b0_0101;

	// minimum segment limits
	localparam logic [31:0] LIMIT_MIN_PLAIN  = 32'h0000_0067;
	localparam logic [31:0] LIMIT_MIN_SHSTK  = 32'h0000_006B;

	// apb register map (byte addresses)
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_XLATE    = 12'h008;
	localparam logic [11:0] REG_LDTSEL   = 12'h00C;
	localparam logic [11:0] REG_TASKREG  = 12'h010;
	localparam logic [11:0] REG_IOMAP    = 12'h014;

	// ctrl field positions and reset value
	localparam int          CTRL_LONG    = 0;
	localparam int          CTRL_SHSTK   = 1;
	localparam int          CTRL_NT      = 2;
	localparam int          CTRL_CPL_LSB = 3;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

	// where the referenced descriptor lives
	typedef enum logic [1:0] {
		TBL_GLOBAL,
		TBL_LOCAL,
		TBL_INTR
	} tscu_table_e;

	// cause of the switch attempt
	typedef enum logic [2:0] {
		SRC_CALL,
		SRC_JUMP,
		SRC_SWINT,
		SRC_EXCEPT,
		SRC_EXTINT,
		SRC_INTERRUPT_RETURN_INSTR,
		SRC_RET,
		SRC_LOADTR
	} tscu_src_e;

	// outcome reported to the core
	typedef enum logic [2:0] {
		RES_NONE,
		RES_SWITCH,
		RES_LOADED,
		RES_GP,
		RES_TS,
		RES_NP
	} tscu_res_e;

	// one switch request from the core
	typedef struct packed {
		tscu_src_e   src;
		tscu_table_e table_sel;
		logic [1:0]  sel_rpl;
		logic [31:0] desc_hi;     // byte +4 word of referenced descriptor
		logic [15:0] target_sel;  // tss selector (gate field or direct)
		logic [15:0] link_sel;    // current task link field
		logic [31:0] tgt_limit;
		logic [1:0]  tgt_dpl;
	} tscu_req_s;

	// answer to the core
	typedef struct packed {
		tscu_res_e   result;
		logic [15:0] new_sel;
		logic [7:0]  save_off;    // where outgoing state is written
	} tscu_rsp_s;

endpackage : tscu_pkg

`default_nettype wire

//--- rtl/tscu_check_unit.sv
/*
 * tscu_check_unit: decides whether a task switch may proceed and which
 * fault it raises, keeps the task register and per-task translation base
 * and local table selector, and exposes them over apb.
 * assumes: the core presents one request as a one-cycle valid pulse with
 * the referenced descriptor already fetched; memory moves are the core's.
 */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module tscu_check_unit (
	// clock and reset
	input  wire logic                clk_sys_i,
	input  wire logic                rst_b_i,
	// apb slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [11:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// switch request from the core
	input  wire logic                req_valid_i,
	input  wire tscu_pkg::tscu_req_s req_i,
	input  wire logic [31:0]         new_xlate_i,
	input  wire logic [15:0]         new_ldtsel_i,
	// answer to the core
	output logic                     rsp_valid_o,
	output tscu_pkg::tscu_rsp_s      rsp_o,
	output logic                     task_busy_o
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [31:0] ctrl_q;
	logic [31:0] xlate_q;
	logic [15:0] ldtsel_q;
	logic [15:0] taskreg_q;
	logic        busy_q;
	logic [15:0] iomap_q;
	logic [2:0]  last_res_q;
	logic        rsp_valid_q;
	tscu_pkg::tscu_rsp_s rsp_q;

	// ctrl fields steer the checks
	wire        long_mode = ctrl_q[tscu_pkg::CTRL_LONG];
	wire        shstk_en  = ctrl_q[tscu_pkg::CTRL_SHSTK];
	wire        nt_flag   = ctrl_q[tscu_pkg::CTRL_NT];
	wire [1:0]  current_privilege_level       = ctrl_q[tscu_pkg::CTRL_CPL_LSB +: 2];

	////////////////////////////////////////////////////////////////////////////
	// descriptor decode
	wire [4:0] st_code  = {req_i.desc_hi[tscu_pkg::GATE_S_BIT],
	                       req_i.desc_hi[tscu_pkg::GATE_TYPE_LSB +: 4]};
	wire       is_gate  = (st_code == tscu_pkg::GATE_TASK_CODE);
	wire       present  = req_i.desc_hi[tscu_pkg::GATE_P_BIT];
	wire [1:0] gate_dpl = req_i.desc_hi[tscu_pkg::GATE_DPL_LSB +: 2];

	// classify the cause
	wire src_far   = (req_i.src == tscu_pkg::SRC_CALL) || (req_i.src == tscu_pkg::SRC_JUMP);
	wire src_intr  = (req_i.src == tscu_pkg::SRC_SWINT) || (req_i.src == tscu_pkg::SRC_EXCEPT)
	               || (req_i.src == tscu_pkg::SRC_EXTINT);
	wire src_interrupt_return_instr  = (req_i.src == tscu_pkg::SRC_INTERRUPT_RETURN_INSTR);
	wire src_ldtr  = (req_i.src == tscu_pkg::SRC_LOADTR);

	// does this request start a switch at all; far gates count from the global or local table, interrupt gates only from the interrupt table
	wire via_gate_far  = src_far && is_gate && (req_i.table_sel != tscu_pkg::TBL_INTR);
	wire via_tss_far   = src_far && !is_gate && (req_i.table_sel == tscu_pkg::TBL_GLOBAL);
	wire via_gate_intr = src_intr && is_gate && (req_i.table_sel == tscu_pkg::TBL_INTR);
	wire via_interrupt_return_instr      = src_interrupt_return_instr && nt_flag;
	wire wants_switch  = via_gate_far || via_tss_far || via_gate_intr || via_interrupt_return_instr;

	////////////////////////////////////////////////////////////////////////////
	// privilege check; interrupt and interrupt_return_instr paths pass unconditionally
	wire gate_priv_ok = (current_privilege_level <= gate_dpl) && (req_i.sel_rpl <= gate_dpl);
	wire tss_priv_ok  = (current_privilege_level <= req_i.tgt_dpl) && (req_i.sel_rpl <= req_i.tgt_dpl);
	wire priv_ok      = via_gate_far ? gate_priv_ok
	                  : via_tss_far  ? tss_priv_ok
	                  : 1'b1;

	// limit check depends on shadow stack enable
	wire [31:0] lim_min  = shstk_en ? tscu_pkg::LIMIT_MIN_SHSTK : tscu_pkg::LIMIT_MIN_PLAIN;
	wire        limit_ok = (req_i.tgt_limit >= lim_min);

	// a gate that is absent faults before privilege and limit are checked; only the long-mode fault outranks it
	wire gate_absent = is_gate && !present;

	// resolve one outcome; privilege outranks limit
	tscu_pkg::tscu_res_e res_d;
	always_comb begin
		res_d = tscu_pkg::RES_NONE;
		if (src_ldtr) begin
			res_d = tscu_pkg::RES_LOADED;
		end else if (req_i.src == tscu_pkg::SRC_RET) begin
			res_d = tscu_pkg::RES_NONE;
		end else if (wants_switch && long_mode) begin
			res_d = tscu_pkg::RES_GP;
		end else if (wants_switch && gate_absent && !via_interrupt_return_instr) begin
			res_d = tscu_pkg::RES_NP;
		end else if (wants_switch && !priv_ok) begin
			res_d = tscu_pkg::RES_GP;
		end else if (wants_switch && !limit_ok) begin
			res_d = tscu_pkg::RES_TS;
		end else if (wants_switch) begin
			res_d = tscu_pkg::RES_SWITCH;
		end
	end

	// selector of the incoming task
	wire [15:0] new_sel = via_interrupt_return_instr ? req_i.link_sel : req_i.target_sel;
	wire        do_switch = req_valid_i && (res_d == tscu_pkg::RES_SWITCH);
	wire        do_load   = req_valid_i && (res_d == tscu_pkg::RES_LOADED);

	// long-mode images only carry stacks and the io offset; no save area.
	// bytes 04h-5Bh hold the privileged and table stack pointers there, so
	// the core must never be pointed at that range for a register dump
	wire [7:0] save_off = long_mode ? 8'h00 : tscu_pkg::TSS32_XLATE;

	////////////////////////////////////////////////////////////////////////////
	// apb decode: single-cycle slave, unmapped reads zero with slverr
	wire apb_acc   = psel_i && penable_i;
	wire apb_wr    = apb_acc && pwrite_i;
	wire hit_ctrl  = (paddr_i == tscu_pkg::REG_CTRL);
	wire hit_stat  = (paddr_i == tscu_pkg::REG_STATUS);
	wire hit_xlate = (paddr_i == tscu_pkg::REG_XLATE);
	wire hit_ldt   = (paddr_i == tscu_pkg::REG_LDTSEL);
	wire hit_tr    = (paddr_i == tscu_pkg::REG_TASKREG);
	wire hit_iomap = (paddr_i == tscu_pkg::REG_IOMAP);
	wire mapped    = hit_ctrl || hit_stat || hit_xlate || hit_ldt || hit_tr || hit_iomap;

	logic [31:0] rdata;
	always_comb begin
		if (hit_ctrl) begin
			rdata = ctrl_q;
		end else if (hit_stat) begin
			rdata = {28'h000_0000, busy_q, last_res_q};
		end else if (hit_xlate) begin
			rdata = xlate_q;
		end else if (hit_ldt) begin
			rdata = {16'h0000, ldtsel_q};
		end else if (hit_tr) begin
			rdata = {16'h0000, taskreg_q};
		end else if (hit_iomap) begin
			rdata = {16'h0000, iomap_q};
		end else begin
			rdata = 32'h0000_0000;
		end
	end

	assign prdata_o  = apb_acc ? rdata : 32'h0000_0000;
	assign pready_o  = 1'b1;
	assign pslverr_o = apb_acc && !mapped;

	////////////////////////////////////////////////////////////////////////////
	// control register: software owns mode, shadow stack, nested flag, cpl
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= tscu_pkg::CTRL_RESET;
		end else if (apb_wr && hit_ctrl) begin
			ctrl_q <= {27'h000_0000, pwrite_i ? pwdata_i[4:0] : ctrl_q[4:0]};
		end
	end

	// io bitmap offset, 16 bits as held at bytes 66h-67h
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			iomap_q <= 16'h0000;
		end else if (apb_wr && hit_iomap) begin
			iomap_q <= pwdata_i[15:0];
		end
	end

	// per-task translation base and local table selector swap on a switch
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xlate_q  <= 32'h0000_0000;
			ldtsel_q <= 16'h0000;
		end else if (do_switch) begin
			xlate_q  <= new_xlate_i;
			ldtsel_q <= new_ldtsel_i;
		end else if (apb_wr && hit_xlate) begin
			xlate_q  <= pwdata_i;
		end else if (apb_wr && hit_ldt) begin
			ldtsel_q <= pwdata_i[15:0];
		end
	end

	// task register and busy mark
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			taskreg_q <= 16'h0000;
			busy_q    <= 1'b0;
		end else if (do_switch || do_load) begin
			taskreg_q <= do_load ? req_i.target_sel : new_sel;
			busy_q    <= 1'b1;
		end
	end

	// answer register; a fault leaves every piece of state above untouched
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rsp_valid_q <= 1'b0;
			rsp_q       <= '0;
			last_res_q  <= 3'h0;
		end else begin
			rsp_valid_q <= req_valid_i;
			if (req_valid_i) begin
				rsp_q.result   <= res_d;
				rsp_q.new_sel  <= new_sel;
				rsp_q.save_off <= save_off;
				last_res_q     <= res_d;
			end
		end
	end

	assign rsp_valid_o = rsp_valid_q;
	assign rsp_o       = rsp_q;
	assign task_busy_o = busy_q;

endmodule // tscu_check_unit

`default_nettype wire

//--- sim/tscu_chk.sv
/*
 * tscu_chk: port-level checks for the task switch check unit.
 * assumes: bound to tscu_check_unit; one clock, async active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module tscu_chk (
	// clock, reset and apb
	input wire logic                clk_sys_i,
	input wire logic                rst_b_i,
	input wire logic                psel_i,
	input wire logic                penable_i,
	input wire logic [11:0]         paddr_i,
	input wire logic                pready_o,
	input wire logic                pslverr_o,
	// switch request and answer
	input wire logic                req_valid_i,
	input wire tscu_pkg::tscu_req_s req_i,
	input wire logic                rsp_valid_o,
	input wire tscu_pkg::tscu_rsp_s rsp_o,
	input wire logic                task_busy_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	// apb: zero wait states, error above the last register
	a_zero_wait: assert property (psel_i && penable_i |-> pready_o) else $error("apb waited");
	a_bad_addr: assert property (psel_i && penable_i && paddr_i > 12'h014 |-> pslverr_o)
		else $error("unmapped access not flagged");
	// every request answered exactly one cycle later, nothing else
	a_rsp_next: assert property (req_valid_i |=> rsp_valid_o) else $error("answer late");
	a_rsp_lone: assert property (!req_valid_i |=> !rsp_valid_o) else $error("stray answer");
	// plain return never switches; interrupt return follows the link
	a_ret_none: assert property (req_valid_i && req_i.src == tscu_pkg::SRC_RET |=>
		rsp_o.result == tscu_pkg::RES_NONE) else $error("return switched");
	a_interrupt_return_instr_link: assert property (req_valid_i && req_i.src == tscu_pkg::SRC_INTERRUPT_RETURN_INSTR ##1
		rsp_o.result == tscu_pkg::RES_SWITCH |-> rsp_o.new_sel == $past(req_i.link_sel))
		else $error("interrupt_return_instr target wrong");
	// load of task register marks busy without switching
	a_load_busy: assert property (req_valid_i && req_i.src == tscu_pkg::SRC_LOADTR |=>
		rsp_o.result == tscu_pkg::RES_LOADED && task_busy_o) else $error("load failed");
	a_busy_cause: assert property ($rose(task_busy_o) |-> rsp_valid_o &&
		rsp_o.result inside {tscu_pkg::RES_SWITCH, tscu_pkg::RES_LOADED})
		else $error("busy without cause");
	// faults must match their cause in the request
	a_np_bit: assert property (rsp_valid_o && rsp_o.result == tscu_pkg::RES_NP |->
		!$past(req_i.desc_hi[15])) else $error("absent fault on present gate");
	a_ts_lim: assert property (rsp_valid_o && rsp_o.result == tscu_pkg::RES_TS |->
		$past(req_i.tgt_limit) < 32'h0000_006B) else $error("limit fault on big limit");
endmodule // tscu_chk

bind tscu_check_unit tscu_chk u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .req_valid_i(req_valid_i), .req_i(req_i),
	.rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .task_busy_o(task_busy_o));

`default_nettype wire

//--- sim/testbench.sv
/*
 * testbench: directed checks of the task switch check unit over apb and
 * the switch request port.
 * assumes: tscu_pkg and tscu_check_unit compiled first; checker bound.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end

module testbench;
	logic                clk_sys_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0;
	logic                psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic                pready_o, pslverr_o, rsp_valid_o, task_busy_o, se;
	logic [11:0]         paddr_i = '0;
	logic [31:0]         pwdata_i = '0, new_xlate_i = '0, prdata_o, q, xe = '0;
	logic [15:0]         new_ldtsel_i = '0, le = '0, te = '0;
	logic [7:0]          k = '0;
	tscu_pkg::tscu_req_s req_i = '0;
	tscu_pkg::tscu_rsp_s rsp_o;
	int                  checks = 0, n_mismatch = 0;
	localparam logic [2:0] NO = tscu_pkg::RES_NONE, SW = tscu_pkg::RES_SWITCH;
	localparam logic [2:0] LD = tscu_pkg::RES_LOADED, GP = tscu_pkg::RES_GP;
	localparam logic [2:0] TS = tscu_pkg::RES_TS, NP = tscu_pkg::RES_NP;

	tscu_check_unit dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.req_valid_i(req_valid_i), .req_i(req_i), .new_xlate_i(new_xlate_i),
		.new_ldtsel_i(new_ldtsel_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
		.task_busy_o(task_busy_o));

	// 50 MHz
	always #10 clk_sys_i = ~clk_sys_i;

	////////////////////////////////////////////////////////////////////////
	// descriptor words: gate with present bit and privilege, or plain tss
	function automatic logic [31:0] g(input logic p, input logic [1:0] d);
		return {16'h0000, p, d, 5'b0_0101, 8'h00};
	endfunction
	function automatic logic [31:0] t(input logic [1:0] d);
		return {16'h0000, 1'b1, d, 5'b0_1001, 8'h00};
	endfunction

	// one apb transfer; waits on pready, bounded only by the watchdog
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		q = prdata_o;
		se = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		ap(1'b0, a, '0);
		`CHK(q, e)
	endtask

	// one switch request; src/table as codes; tracks what the unit must hold
	task automatic sw(input logic [2:0] s, input logic [1:0] tb, r, input logic [31:0] dh,
		input logic [7:0] lm, input logic [1:0] td, input logic [2:0] e);
		@(posedge clk_sys_i);
		k = k + 8'h01;
		req_valid_i <= 1'b1;
		req_i <= '{tscu_pkg::tscu_src_e'(s), tscu_pkg::tscu_table_e'(tb), r, dh,
			16'h0028, 16'h0030, {24'h00_0000, lm}, td};
		new_xlate_i <= {k, k, k, k};
		new_ldtsel_i <= {k, k};
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		#1;
		`CHK(rsp_valid_o, 1'b1)
		`CHK(rsp_o.result, e)
		if (e == SW || e == LD) te = (s == 3'd5) ? 16'h0030 : 16'h0028;
		if (e == SW) begin
			xe = {k, k, k, k};
			le = {k, k};
			`CHK(rsp_o.new_sel, te)
		end
	endtask

	// saved per-task state must hold only what the last good switch loaded
	task automatic state_ok;
		rd(tscu_pkg::REG_XLATE, xe);
		rd(tscu_pkg::REG_LDTSEL, {16'h0000, le});
		rd(tscu_pkg::REG_TASKREG, {16'h0000, te});
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs about a hundred cycles
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rd(tscu_pkg::REG_CTRL, tscu_pkg::CTRL_RESET);
		ap(1'b1, tscu_pkg::REG_STATUS, 32'hFFFF_FFFF);
		rd(tscu_pkg::REG_STATUS, '0);
		rd(12'h0FC, '0);
		`CHK(se, 1'b1)
		ap(1'b1, tscu_pkg::REG_IOMAP, 32'hFFFF_0068);
		rd(tscu_pkg::REG_IOMAP, 32'h0000_0068);
		sw(3'd7, 2'd0, 2'd0, t(2'd0), 8'h67, 2'd0, LD);
		`CHK(task_busy_o, 1'b1)
		sw(3'd6, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h67, 2'd0, NO);
		sw(3'd0, 2'd0, 2'd3, g(1'b1, 2'd3), 8'h67, 2'd0, SW);
		`CHK(rsp_o.save_off, tscu_pkg::TSS32_XLATE)
		sw(3'd1, 2'd1, 2'd0, g(1'b1, 2'd0), 8'h67, 2'd3, SW);
		sw(3'd0, 2'd0, 2'd0, g(1'b0, 2'd3), 8'h67, 2'd0, NP);
		sw(3'd0, 2'd0, 2'd2, g(1'b1, 2'd1), 8'h67, 2'd3, GP);
		sw(3'd1, 2'd0, 2'd0, t(2'd0), 8'h67, 2'd0, SW);
		sw(3'd1, 2'd1, 2'd0, t(2'd0), 8'h67, 2'd0, NO);
		sw(3'd0, 2'd0, 2'd1, t(2'd0), 8'h67, 2'd0, GP);
		sw(3'd0, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h66, 2'd0, TS);
		sw(3'd0, 2'd0, 2'd3, g(1'b1, 2'd0), 8'h66, 2'd0, GP);
		state_ok;
		sw(3'd2, 2'd2, 2'd3, g(1'b1, 2'd0), 8'h67, 2'd0, SW);
		sw(3'd3, 2'd2, 2'd3, g(1'b1, 2'd0), 8'h67, 2'd0, SW);
		sw(3'd4, 2'd2, 2'd3, g(1'b1, 2'd0), 8'h67, 2'd0, SW);
		sw(3'd2, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h67, 2'd0, NO);
		sw(3'd5, 2'd0, 2'd0, t(2'd0), 8'h67, 2'd0, NO);
		ap(1'b1, tscu_pkg::REG_CTRL, 32'h0000_001C);
		sw(3'd5, 2'd0, 2'd0, t(2'd0), 8'h67, 2'd0, SW);
		sw(3'd0, 2'd1, 2'd3, g(1'b1, 2'd3), 8'h67, 2'd0, SW);
		sw(3'd0, 2'd0, 2'd0, t(2'd0), 8'h67, 2'd0, GP);
		ap(1'b1, tscu_pkg::REG_CTRL, 32'h0000_0002);
		sw(3'd0, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h6B, 2'd0, SW);
		sw(3'd0, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h6A, 2'd0, TS);
		state_ok;
		ap(1'b1, tscu_pkg::REG_CTRL, 32'h0000_0001);
		sw(3'd0, 2'd0, 2'd0, g(1'b1, 2'd3), 8'h67, 2'd0, GP);
		`CHK(rsp_o.save_off, 8'h00)
		sw(3'd2, 2'd2, 2'd0, g(1'b1, 2'd3), 8'h67, 2'd0, GP);
		state_ok;
		tally_and_finish;
	end
endmodule // testbench

`default_nettype wire
